//--- logic/rsa_pkg.sv
// Constants and types of the register set and arithmetic unit
package rsa_pkg;
  localparam logic [7:0] OFS_LOW = 8'h00;
  localparam logic [7:0] OFS_HIGH = 8'h04;
  localparam logic [7:0] OFS_MAIN = 8'h08;
  localparam logic [7:0] OFS_FIRST = 8'h0C;
  localparam logic [7:0] OFS_SECOND = 8'h10;
  localparam logic [7:0] OFS_FETCH = 8'h14;
  localparam logic [7:0] OFS_STACK = 8'h18;
  localparam logic [7:0] OFS_BASE = 8'h1C;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_CUSTOM = 8'h24;
  localparam logic [7:0] OFS_PEND = 8'h28;
  localparam logic [7:0] OFS_ACTIVE = 8'h2C;
  localparam logic [7:0] OFS_GPAGE = 8'h30;
  localparam logic [7:0] OFS_FPAGE = 8'h34;
  localparam logic [7:0] OFS_SPAGE = 8'h38;
  localparam logic [7:0] OFS_OPND = 8'h3C;
  localparam logic [7:0] OFS_CMD = 8'h40;
  localparam logic [7:0] OFS_RESULT = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] OFS_ACTRL = 8'h4C;
  localparam logic [7:0] OFS_DADDR = 8'h50;
  localparam logic [7:0] OFS_PADDR = 8'h54;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'hC0;
  localparam int CMD_W = 12;
  localparam int AMODE_LSB = 16;
  localparam int BANK_BIT = 15;
  localparam logic [2:0] SEL_LATCH = 3'h0;
  localparam logic [2:0] SEL_LOW = 3'h1;
  localparam logic [2:0] SEL_HIGH = 3'h2;
  localparam logic [2:0] SEL_PAIR = 3'h3;
  localparam logic [2:0] SEL_MAIN = 3'h4;
  localparam logic [2:0] SEL_FIRST = 3'h5;
  localparam logic [2:0] SEL_SECOND = 3'h6;
  localparam logic [2:0] SEL_STACK = 3'h7;
  typedef enum logic [4:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_CP, OP_BIT,
    OP_INC, OP_DEC, OP_MLT, OP_DIV, OP_CPL, OP_NEG, OP_RL, OP_RLC, OP_RR,
    OP_RRC, OP_SLA, OP_SLL, OP_SRA, OP_SRL, OP_PACK, OP_UPCK, OP_SEP
  } rsa_op_t;
  typedef enum logic [2:0] {
    AM_MAIN, AM_ABS16, AM_FIRST_DISP, AM_SECOND_DISP, AM_BASE8, AM_STACK,
    AM_FIRST, AM_SECOND
  } rsa_amode_t;
  typedef struct packed {
    logic i1, i0, u, d, n, v, c, z;
  } rsa_flags_t;
  typedef struct packed {
    logic [2:0] dst;
    logic [2:0] src;
    logic w16;
    rsa_op_t op;
  } rsa_cmd_t;
  function automatic logic rsa_wide(input int v);
    return v >= 2;
  endfunction
  function automatic logic rsa_muldiv(input int v);
    return v == 1 || v == 3;
  endfunction
endpackage

//--- logic/rsa_core.sv
// Register set, arithmetic unit and address forming of the core
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module rsa_core #(
  parameter int VARIANT = 3
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MODE,
  input wire logic [3:0] COND_IN,
  input wire logic [7:0] STACK_PAGE_IN,
  input wire logic IRQ_ACCEPT,
  input wire logic [1:0] IRQ_LEVEL,
  input wire logic FETCH_STEP,
  output logic [23:0] PROG_ADDR,
  output logic [23:0] DATA_ADDR,
  output logic [3:0] COND_FLAGS,
  output rsa_pkg::rsa_flags_t FLAGS
);
  import rsa_pkg::*;
  localparam logic WIDE = rsa_wide(VARIANT);
  localparam logic MULDIV = rsa_muldiv(VARIANT);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [7:0] spp_s1_q, spp_s2_q;
  logic [3:0] cond_s1_q, cond_s2_q;
  logic mode_s1_q, mode_s2_q;
  always_ff @(posedge CLK) begin
    spp_s1_q <= STACK_PAGE_IN;
    spp_s2_q <= spp_s1_q;
    cond_s1_q <= COND_IN;
    cond_s2_q <= cond_s1_q;
    mode_s1_q <= MODE;
    mode_s2_q <= mode_s1_q;
  end
  assign COND_FLAGS = cond_s2_q;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] low_store_q, high_store_q, base_hi_q;
  logic [15:0] main_ptr_q, first_ptr_q, second_ptr_q, fetch_q, stack_q;
  logic [7:0] pend_bank_q, act_bank_q, gen_page_q, f_page_q, s_page_q;
  logic bank_load_q;
  rsa_flags_t flags_q;
  logic [15:0] temp0_q, temp1_q, result_q, imm_q;
  rsa_cmd_t cmd_q, cmd_w;
  logic busy_q, done_q, refused_q;
  rsa_amode_t amode_q;
  logic [23:0] paddr_q, daddr_q;
  logic [31:0] prdata_q;

  logic wr, setup, start;
  assign wr = PSEL && PENABLE && PWRITE;
  assign setup = PSEL && !PENABLE;
  assign cmd_w = rsa_cmd_t'(PWDATA[CMD_W-1:0]);
  assign start = wr && PADDR == OFS_CMD && !busy_q;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      OFS_PEND, OFS_ACTIVE, OFS_GPAGE, OFS_FPAGE, OFS_SPAGE: begin
        return WIDE;
      end
      OFS_LOW, OFS_HIGH, OFS_MAIN, OFS_FIRST, OFS_SECOND, OFS_FETCH,
      OFS_STACK, OFS_BASE, OFS_FLAGS, OFS_CUSTOM, OFS_OPND, OFS_CMD,
      OFS_RESULT, OFS_STATUS, OFS_ACTRL, OFS_DADDR, OFS_PADDR: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  function automatic logic [7:0] page(input logic [7:0] p);
    return WIDE ? p : RST_BYTE;
  endfunction

  function automatic logic msb(input logic [15:0] v, input logic w);
    return w ? v[15] : v[7];
  endfunction

  // ----------------------------------------
  // Arithmetic unit
  // ----------------------------------------
  logic w, zw, ci, c_n, v_n, upd_c, upd_v, upd_n, wb;
  logic [15:0] a, b, res, quo;
  logic [16:0] sum, dif;
  logic [7:0] rem;
  rsa_op_t op;
  assign op = cmd_q.op;
  always_comb begin
    w = cmd_q.w16 && op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP,
                                OP_INC, OP_DEC};
    zw = w || op inside {OP_MLT, OP_DIV, OP_UPCK, OP_SEP};
    a = w ? temp0_q : {8'h00, temp0_q[7:0]};
    b = w ? temp1_q : {8'h00, temp1_q[7:0]};
    // Unpack mode zeroes the upper nibbles of byte add/subtract
    if (!w && flags_q.u &&
        op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC}) begin
      a = {12'h000, temp0_q[3:0]};
      b = {12'h000, temp1_q[3:0]};
    end
    ci = op inside {OP_ADC, OP_SBC} && flags_q.c;
    if (op inside {OP_INC, OP_DEC}) begin
      b = 16'h0001;
      ci = 1'b0;
    end
    sum = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
    dif = {1'b0, a} - {1'b0, b} - {16'h0000, ci};
    quo = (temp1_q[7:0] == 8'h00) ? 16'hFFFF : temp0_q / {8'h00, temp1_q[7:0]};
    rem = (temp1_q[7:0] == 8'h00) ? 8'hFF : 8'(temp0_q % 16'(temp1_q[7:0]));
    res = 16'h0000;
    c_n = flags_q.c;
    v_n = flags_q.v;
    upd_c = 1'b1;
    upd_v = 1'b1;
    upd_n = 1'b1;
    wb = 1'b1;
    case (op)
      OP_ADD, OP_ADC, OP_INC: begin
        res = sum[15:0];
        c_n = w ? sum[16] : sum[8];
        v_n = msb(a, w) == msb(b, w) && msb(res, w) != msb(a, w);
      end
      OP_SUB, OP_SBC, OP_CP, OP_DEC, OP_NEG: begin
        if (op == OP_NEG) begin
          res = 16'h0000 - a;
          c_n = a[7:0] != 8'h00;
          v_n = a[7:0] == 8'h80;
        end else begin
          res = dif[15:0];
          c_n = w ? dif[16] : dif[8];
          v_n = msb(a, w) != msb(b, w) && msb(res, w) != msb(a, w);
        end
        wb = op != OP_CP;
      end
      OP_AND, OP_BIT: begin
        res = a & b;
        wb = op != OP_BIT;
      end
      OP_OR: res = a | b;
      OP_XOR: res = a ^ b;
      OP_CPL: res = {8'h00, ~a[7:0]};
      OP_MLT: begin
        res = temp0_q[7:0] * temp1_q[7:0];
        c_n = 1'b0;
        v_n = 1'b0;
      end
      OP_DIV: begin
        res = {rem, quo[7:0]};
        c_n = 1'b0;
        v_n = quo[15:8] != 8'h00;
      end
      OP_RL: {c_n, res[7:0]} = {a[7:0], flags_q.c};
      OP_RLC: {c_n, res[7:0]} = {a[7], a[6:0], a[7]};
      OP_RR: {res[7:0], c_n} = {flags_q.c, a[7:0]};
      OP_RRC: {res[7:0], c_n} = {a[0], a[7:0]};
      OP_SLA, OP_SLL: {c_n, res[7:0]} = {a[7:0], 1'b0};
      OP_SRA: {res[7:0], c_n} = {a[7], a[7:0]};
      OP_SRL: {res[7:0], c_n} = {1'b0, a[7:0]};
      OP_PACK: res = {8'h00, temp0_q[11:8], temp0_q[3:0]};
      OP_UPCK: res = {4'h0, temp0_q[7:4], 4'h0, temp0_q[3:0]};
      OP_SEP: res = {{8{temp0_q[7]}}, temp0_q[7:0]};
      default: wb = 1'b0;
    endcase
    if (op inside {OP_AND, OP_OR, OP_XOR, OP_BIT, OP_CPL, OP_PACK,
                   OP_UPCK, OP_SEP}) begin
      upd_c = 1'b0;
      upd_v = 1'b0;
    end
    if (op inside {OP_INC, OP_DEC}) begin
      upd_c = 1'b0;
      upd_v = 1'b0;
      upd_n = 1'b0;
    end
    if (op inside {OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SLA, OP_SLL, OP_SRA,
                   OP_SRL}) begin
      upd_v = 1'b0;
    end
  end

  function automatic logic [15:0] pick(input logic [2:0] s);
    case (s)
      SEL_LOW: return {8'h00, low_store_q};
      SEL_HIGH: return {8'h00, high_store_q};
      SEL_PAIR: return {high_store_q, low_store_q};
      SEL_MAIN: return main_ptr_q;
      SEL_FIRST: return first_ptr_q;
      SEL_SECOND: return second_ptr_q;
      SEL_STACK: return stack_q;
      default: return temp0_q;
    endcase
  endfunction

  // ----------------------------------------
  // Operation sequencing
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_q <= rsa_cmd_t'(RST_WORD[CMD_W-1:0]);
      temp0_q <= RST_WORD;
      temp1_q <= RST_WORD;
      result_q <= RST_WORD;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= busy_q;
      if (wr && PADDR == OFS_OPND && !busy_q) begin
        temp0_q <= PWDATA[15:0];
        temp1_q <= PWDATA[31:16];
      end
      if (start) begin
        // No multiply/divide hardware: command dropped, status marks it
        refused_q <= !MULDIV && cmd_w.op inside {OP_MLT, OP_DIV};
        if (MULDIV || !(cmd_w.op inside {OP_MLT, OP_DIV})) begin
          cmd_q <= cmd_w;
          busy_q <= 1'b1;
          if (cmd_w.src != SEL_LATCH) begin
            temp0_q <= pick(cmd_w.src);
          end
        end
      end
      if (busy_q) begin
        result_q <= res;
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      flags_q <= rsa_flags_t'(RST_FLAGS);
    end else begin
      if (wr && PADDR == OFS_FLAGS) begin
        flags_q <= rsa_flags_t'(PWDATA[7:0]);
      end else if (busy_q) begin
        flags_q.z <= zw ? res == 16'h0000 : res[7:0] == 8'h00;
        if (upd_n) flags_q.n <= msb(res, zw);
        if (upd_c) flags_q.c <= c_n;
        if (upd_v) flags_q.v <= v_n;
      end
      // Interrupt acceptance wins over a software write of the level
      if (IRQ_ACCEPT) begin
        {flags_q.i1, flags_q.i0} <= IRQ_LEVEL;
      end
    end
  end
  assign FLAGS = flags_q;

  // ----------------------------------------
  // Register set
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      low_store_q <= RST_BYTE;
      high_store_q <= RST_BYTE;
      base_hi_q <= RST_BYTE;
      main_ptr_q <= RST_WORD;
      first_ptr_q <= RST_WORD;
      second_ptr_q <= RST_WORD;
      fetch_q <= RST_WORD;
      stack_q <= RST_WORD;
    end else begin
      if (FETCH_STEP) fetch_q <= fetch_q + 16'h0001;
      if (busy_q && wb) begin
        case (cmd_q.dst)
          SEL_LOW: low_store_q <= res[7:0];
          SEL_HIGH: high_store_q <= res[7:0];
          SEL_PAIR: {high_store_q, low_store_q} <= res;
          SEL_MAIN: main_ptr_q <= res;
          SEL_FIRST: first_ptr_q <= res;
          SEL_SECOND: second_ptr_q <= res;
          SEL_STACK: stack_q <= res;
          default: ;
        endcase
      end
      if (wr) begin
        case (PADDR)
          OFS_LOW: low_store_q <= PWDATA[7:0];
          OFS_HIGH: high_store_q <= PWDATA[7:0];
          OFS_MAIN: main_ptr_q <= PWDATA[15:0];
          OFS_FIRST: first_ptr_q <= PWDATA[15:0];
          OFS_SECOND: second_ptr_q <= PWDATA[15:0];
          OFS_FETCH: fetch_q <= PWDATA[15:0];
          OFS_STACK: stack_q <= PWDATA[15:0];
          OFS_BASE: base_hi_q <= PWDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  // Banks and pages exist only in wide variants
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_bank_q <= RST_BYTE;
      act_bank_q <= RST_BYTE;
      bank_load_q <= 1'b0;
      gen_page_q <= RST_BYTE;
      f_page_q <= RST_BYTE;
      s_page_q <= RST_BYTE;
    end else begin
      bank_load_q <= WIDE && wr && PADDR == OFS_PEND;
      if (bank_load_q) act_bank_q <= pend_bank_q;
      if (WIDE && wr) begin
        case (PADDR)
          OFS_PEND: pend_bank_q <= PWDATA[7:0];
          OFS_GPAGE: gen_page_q <= PWDATA[7:0];
          OFS_FPAGE: f_page_q <= PWDATA[7:0];
          OFS_SPAGE: s_page_q <= PWDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Address forming
  // ----------------------------------------
  logic [23:0] daddr_n, paddr_n;
  logic [15:0] disp;
  assign disp = {8'h00, main_ptr_q[7:0]};
  always_comb begin
    case (amode_q)
      AM_MAIN: daddr_n = {page(gen_page_q), main_ptr_q};
      AM_ABS16: daddr_n = {page(gen_page_q), imm_q};
      AM_FIRST_DISP: daddr_n = {page(f_page_q), first_ptr_q + disp};
      AM_SECOND_DISP: daddr_n = {page(s_page_q), second_ptr_q + disp};
      AM_BASE8: daddr_n = {page(gen_page_q), base_hi_q, imm_q[7:0]};
      AM_STACK: daddr_n = {page(spp_s2_q), stack_q};
      AM_FIRST: daddr_n = {page(f_page_q), first_ptr_q};
      AM_SECOND: daddr_n = {page(s_page_q), second_ptr_q};
      default: daddr_n = 24'h000000;
    endcase
    // Top half of the fetch range is banked in maximum mode
    if (WIDE && mode_s2_q && fetch_q[BANK_BIT]) begin
      paddr_n = {1'b0, act_bank_q, fetch_q[BANK_BIT-1:0]};
    end else begin
      paddr_n = {8'h00, fetch_q};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      amode_q <= AM_MAIN;
      imm_q <= RST_WORD;
      daddr_q <= 24'h000000;
      paddr_q <= 24'h000000;
    end else begin
      if (wr && PADDR == OFS_ACTRL) begin
        imm_q <= PWDATA[15:0];
        amode_q <= rsa_amode_t'(PWDATA[AMODE_LSB+2:AMODE_LSB]);
      end
      daddr_q <= daddr_n;
      paddr_q <= paddr_n;
    end
  end
  assign DATA_ADDR = daddr_q;
  assign PROG_ADDR = paddr_q;

  // ----------------------------------------
  // APB read side
  // ----------------------------------------
  logic [31:0] rdata;
  always_comb begin
    case (PADDR)
      OFS_LOW: rdata = {24'h0, low_store_q};
      OFS_HIGH: rdata = {24'h0, high_store_q};
      OFS_MAIN: rdata = {16'h0, main_ptr_q};
      OFS_FIRST: rdata = {16'h0, first_ptr_q};
      OFS_SECOND: rdata = {16'h0, second_ptr_q};
      OFS_FETCH: rdata = {16'h0, fetch_q};
      OFS_STACK: rdata = {16'h0, stack_q};
      OFS_BASE: rdata = {24'h0, base_hi_q};
      OFS_FLAGS: rdata = {24'h0, flags_q};
      OFS_CUSTOM: rdata = {28'h0, cond_s2_q};
      OFS_PEND: rdata = {24'h0, page(pend_bank_q)};
      OFS_ACTIVE: rdata = {24'h0, page(act_bank_q)};
      OFS_GPAGE: rdata = {24'h0, page(gen_page_q)};
      OFS_FPAGE: rdata = {24'h0, page(f_page_q)};
      OFS_SPAGE: rdata = {24'h0, page(s_page_q)};
      OFS_OPND: rdata = {temp1_q, temp0_q};
      OFS_CMD: rdata = {20'h0, cmd_q};
      OFS_RESULT: rdata = {16'h0, result_q};
      OFS_STATUS: rdata = {29'h0, refused_q, done_q, busy_q};
      OFS_ACTRL: rdata = {13'h0, amode_q, imm_q};
      OFS_DADDR: rdata = {8'h0, daddr_q};
      OFS_PADDR: rdata = {8'h0, paddr_q};
      default: rdata = 32'h0;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) prdata_q <= 32'h0;
    else if (setup) prdata_q <= is_mapped(PADDR) ? rdata : 32'h0;
  end
  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !is_mapped(PADDR);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_BANK_LOAD: assert property (@(posedge CLK) disable iff (RST)
    (WIDE && wr && PADDR == OFS_PEND) |-> ##2
      act_bank_q == $past(PWDATA[7:0], 2))
    else $error("active bank not loaded from pending bank");
  AST_COND_FOLLOW: assert property (@(posedge CLK) disable iff (RST)
    $past(COND_IN, 2) == $past(COND_IN, 3) |-> COND_FLAGS == $past(COND_IN, 2))
    else $error("custom flags do not follow inputs");
  AST_ZERO_FLAG: assert property (@(posedge CLK) disable iff (RST)
    (busy_q && !(wr && PADDR == OFS_FLAGS)) |=>
      flags_q.z == (zw ? result_q == 16'h0 : result_q[7:0] == 8'h0))
    else $error("zero flag disagrees with result");
  AST_RESULT_TIME: assert property (@(posedge CLK) disable iff (RST)
    (start && !(cmd_w.op inside {OP_MLT, OP_DIV})) |=> busy_q ##1
      (!busy_q && done_q))
    else $error("result not captured one cycle after start");
  AST_NO_MULDIV: assert property (@(posedge CLK) disable iff (RST)
    (!MULDIV && start && cmd_w.op inside {OP_MLT, OP_DIV}) |=>
      (!busy_q && refused_q))
    else $error("multiply or divide accepted without hardware");
  AST_IRQ_MASK: assert property (@(posedge CLK) disable iff (RST)
    IRQ_ACCEPT |=> {flags_q.i1, flags_q.i0} == $past(IRQ_LEVEL))
    else $error("interrupt level bits not raised");
  AST_MIN_MODE: assert property (@(posedge CLK) disable iff (RST)
    (!mode_s2_q || !WIDE) |=> PROG_ADDR[23:16] == 8'h00)
    else $error("program address leaves 64K area");
  AST_NARROW: assert property (@(posedge CLK) disable iff (RST)
    !WIDE |-> (DATA_ADDR[23:16] == 8'h00 && act_bank_q == RST_BYTE))
    else $error("narrow variant drives page bits");
  AST_STACK_PAGE: assert property (@(posedge CLK) disable iff (RST)
    (WIDE && amode_q == AM_STACK) |=> DATA_ADDR == {$past(spp_s2_q),
      $past(stack_q)})
    else $error("stack page not on top address bits");
endmodule

//--- testbench/rsa_partner.sv
// Sequencer and peripheral model driving the core's side pins
`timescale 1ns/1ps
module rsa_partner (
  input wire logic clk,
  output logic mode,
  output logic [3:0] cond,
  output logic [7:0] stack_page,
  output logic irq_accept,
  output logic [1:0] irq_level,
  output logic fetch_step
);
  initial begin
    mode = 1'b0;
    cond = 4'h0;
    stack_page = 8'h00;
    irq_accept = 1'b0;
    irq_level = 2'h0;
    fetch_step = 1'b0;
  end
  // Status levels change only just after an edge
  task automatic set_pins(input logic m, input logic [3:0] c,
                          input logic [7:0] p);
    @(posedge clk);
    mode <= m;
    cond <= c;
    stack_page <= p;
  endtask
  // One-cycle pulse; level is garbage outside it, like a real sequencer
  task automatic pulse(input logic irq, input logic [1:0] lvl);
    @(posedge clk);
    irq_accept <= irq;
    fetch_step <= !irq;
    irq_level <= lvl;
    @(posedge clk);
    irq_accept <= 1'b0;
    fetch_step <= 1'b0;
    irq_level <= ~lvl;
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench of the register set and arithmetic unit
`timescale 1ns/1ps
module testbench;
  import rsa_pkg::*;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MODE;
  logic IRQ_ACCEPT, FETCH_STEP, er;
  logic [7:0] PADDR, STACK_PAGE_IN;
  logic [31:0] PWDATA, PRDATA, rd, n_prdata, nrd;
  logic [3:0] COND_IN, COND_FLAGS;
  logic [1:0] IRQ_LEVEL;
  logic [23:0] PROG_ADDR, DATA_ADDR, n_prog_addr, n_data_addr;
  rsa_flags_t FLAGS;
  int num_errors = 0;
  int n_tests = 0;
  rsa_core #(.VARIANT(3)) rsa_core_inst (.CLK(CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MODE(MODE), .COND_IN(COND_IN), .STACK_PAGE_IN(STACK_PAGE_IN),
    .IRQ_ACCEPT(IRQ_ACCEPT), .IRQ_LEVEL(IRQ_LEVEL),
    .FETCH_STEP(FETCH_STEP), .PROG_ADDR(PROG_ADDR),
    .DATA_ADDR(DATA_ADDR), .COND_FLAGS(COND_FLAGS), .FLAGS(FLAGS));
  // Narrow variant without multiply/divide shares the bus and the pins
  if (1) begin : narrow
    rsa_core #(.VARIANT(0)) rsa_core_inst (.CLK(CLK), .RST(RST),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(n_prdata), .PREADY(), .PSLVERR(),
      .MODE(MODE), .COND_IN(COND_IN), .STACK_PAGE_IN(STACK_PAGE_IN),
      .IRQ_ACCEPT(IRQ_ACCEPT), .IRQ_LEVEL(IRQ_LEVEL),
      .FETCH_STEP(FETCH_STEP), .PROG_ADDR(n_prog_addr),
      .DATA_ADDR(n_data_addr), .COND_FLAGS(), .FLAGS());
  end
  rsa_partner rsa_partner_inst (.clk(CLK), .mode(MODE), .cond(COND_IN),
    .stack_page(STACK_PAGE_IN), .irq_accept(IRQ_ACCEPT),
    .irq_level(IRQ_LEVEL), .fetch_step(FETCH_STEP));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    nrd = n_prdata;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Status polled until busy drops; done lasts one cycle, yet the first poll still reads it.
  // A hang here is left to the watchdog.
  task automatic alu(input logic [31:0] opnd, input rsa_cmd_t c);
    apb(1'b1, OFS_OPND, opnd);
    apb(1'b1, OFS_CMD, {20'h0, c});
    rd = 32'h1;
    while (rd[0] !== 1'b0) begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] ofs [11] = '{OFS_LOW, OFS_HIGH, OFS_MAIN, OFS_FIRST,
      OFS_SECOND, OFS_FETCH, OFS_STACK, OFS_BASE, OFS_GPAGE, OFS_FPAGE,
      OFS_SPAGE};
    int wid [11] = '{8, 8, 16, 16, 16, 16, 16, 8, 8, 8, 8};
    for (int i = 0; i < 11; i++) begin
      rchk("reset value", ofs[i], 32'h0);
      apb(1'b1, ofs[i], 32'hFFFF_FFFF);
      rchk("width", ofs[i], (32'h1 << wid[i]) - 32'h1);
    end
    rchk("flags reset", OFS_FLAGS, 32'h0000_00C0);
    apb(1'b1, OFS_ACTIVE, 32'h0000_0077);
    rchk("active read only", OFS_ACTIVE, 32'h0);
    apb(1'b1, 8'h80, 32'hFFFF_FFFF);
    chk("unmapped error", 32'h1, {31'h0, er});
    rchk("unmapped read", 8'h80, 32'h0);
  endtask
  task automatic t_alu();
    alu(32'h0001_FFFF, '{SEL_LATCH, SEL_LATCH, 1'b1, OP_ADD});
    rchk("add16 result", OFS_RESULT, 32'h0);
    rchk("add16 flags", OFS_FLAGS, 32'h0000_00C3);
    alu(32'h0001_007F, '{SEL_LATCH, SEL_LATCH, 1'b0, OP_ADD});
    rchk("add8 result", OFS_RESULT, 32'h0000_0080);
    rchk("add8 flags", OFS_FLAGS, 32'h0000_00CC);
    alu(32'h0010_0010, '{SEL_LATCH, SEL_LATCH, 1'b0, OP_MLT});
    rchk("mlt result", OFS_RESULT, 32'h0000_0100);
    rchk("mlt flags", OFS_FLAGS, 32'h0000_00C0);
    rchk("mlt refused", OFS_STATUS, 32'h0);
    chk("narrow refused", 32'h0000_0004, nrd);
    alu(32'h0007_0064, '{SEL_LATCH, SEL_LATCH, 1'b0, OP_DIV});
    rchk("div result", OFS_RESULT, 32'h0000_020E);
    rchk("div flags", OFS_FLAGS, 32'h0000_00C0);
    apb(1'b1, OFS_LOW, 32'h0000_00FF);
    apb(1'b1, OFS_HIGH, 32'h0000_0012);
    alu(32'h0, '{SEL_PAIR, SEL_PAIR, 1'b1, OP_INC});
    rchk("pair low", OFS_LOW, 32'h0);
    rchk("pair high", OFS_HIGH, 32'h0000_0013);
  endtask
  task automatic t_addr();
    logic [2:0] md [6] = '{3'h5, 3'h4, 3'h2, 3'h7, 3'h1, 3'h3};
    logic [31:0] ex [6] = '{32'h7A1234, 32'h112233, 32'h441005, 32'h550ABC,
      32'h110033, 32'h550AC1};
    apb(1'b1, OFS_PEND, 32'h0000_0005);
    apb(1'b1, OFS_FETCH, 32'h0000_8000);
    rsa_partner_inst.set_pins(1'b1, 4'hA, 8'h7A);
    repeat (4) @(posedge CLK);
    chk("prog addr max", 32'h0002_8000, {8'h0, PROG_ADDR});
    chk("narrow prog addr", 32'h0000_8000, {8'h0, n_prog_addr});
    chk("cond max", 32'hA, {28'h0, COND_FLAGS});
    rchk("active bank", OFS_ACTIVE, 32'h0000_0005);
    chk("narrow active bank", 32'h0, nrd);
    rsa_partner_inst.set_pins(1'b0, 4'h5, 8'h7A);
    repeat (4) @(posedge CLK);
    chk("prog addr min", 32'h0000_8000, {8'h0, PROG_ADDR});
    rchk("custom flags", OFS_CUSTOM, 32'h0000_0005);
    rsa_partner_inst.pulse(1'b0, 2'h0);
    rchk("fetch step", OFS_FETCH, 32'h0000_8001);
    apb(1'b1, OFS_STACK, 32'h0000_1234);
    apb(1'b1, OFS_GPAGE, 32'h0000_0011);
    apb(1'b1, OFS_BASE, 32'h0000_0022);
    apb(1'b1, OFS_FPAGE, 32'h0000_0044);
    apb(1'b1, OFS_FIRST, 32'h0000_1000);
    apb(1'b1, OFS_MAIN, 32'h0000_0005);
    apb(1'b1, OFS_SPAGE, 32'h0000_0055);
    apb(1'b1, OFS_SECOND, 32'h0000_0ABC);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_ACTRL, {13'h0, md[i], 16'h0033});
      repeat (3) @(posedge CLK);
      chk("data addr", ex[i], {8'h0, DATA_ADDR});
      chk("narrow daddr", {16'h0, ex[i][15:0]}, {8'h0, n_data_addr});
    end
  endtask
  task automatic t_irq();
    rsa_partner_inst.pulse(1'b1, 2'h1);
    rchk("irq level", OFS_FLAGS, 32'h0000_0040);
    chk("flags port", 32'h0000_0040, {24'h0, FLAGS});
  endtask
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_alu();
    t_addr();
    t_irq();
    stop_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    stop_test();
  end
endmodule
